// ==== core/sfsc_top.sv ====
// Purpose: Status word and serial command framing of a serial NOR flash.
// Assumes: spi_sclk is the link clock; mode 0 framing; rst is power-up.
// Notes: Non-volatile bits are loaded from nv_init while rst is high.
//
// Summary of operation
// - Busy bit set during program, erase, non-volatile status write.
// - Write latch bit gates writes, programs, erases.
// - Protect field written by status write, guards array.
// - Protect field writable only without hardware protection.
// - Chip erase allowed with low protect ones, invert.
// - Guards zero: status writable whenever latch set.
// - Guards zero-one, pin low, quad clear: status locked.
// - Guards zero-one, pin high: writable after latch.
// - Guards one-zero: locked until power cycle clears.
// - Both guards one: status permanently locked.
// - Quad bit turns protect/hold pins into data lines.
// - Lock bits set individually, never clear.
// - Invert bit flips which region is protected.
// - Suspend sets erase or program paused flag.
// - Resume and power cycle clear paused flags.
// - Opcode MSB first, latched on rising clock.
// - Raising select ends reads, device deselects.
// - Write-type commands need byte-aligned clock count.
// - Partial program byte does nothing, latch stays.
// - Latch cleared by reset, disallow, completed writes.
// - Pin low with quad clear guards protect field and guard bits.
`include "sfsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sfsc_top
  import sfsc_pkg::*;
#(
  parameter int STAT_WRITE_CYC = `SFSC_STAT_WRITE_CYC,
  parameter int PROG_CYC = `SFSC_PROG_CYC,
  parameter int ERASE_CYC = `SFSC_ERASE_CYC,
  parameter int CHIP_ERASE_CYC = `SFSC_CHIP_ERASE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic wp_n,
  input wire logic [15:0] nv_init,
  output logic [15:0] status_control_word,
  output logic quad_lines_on,
  output logic pin_protect_hold_fn,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr
);

  // ----------------------------------------
  // Link domain: shifting on spi_sclk
  // ----------------------------------------
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] shift_q;
  logic [7:0] rx_byte;
  logic [7:0] byte_q;
  logic tgl_q;
  logic first_q;
  logic op_seen_q;
  logic rd_on_q;
  logic rd_hi_q;
  logic byte_done;
  logic [15:0] st_meta_q;
  logic [15:0] st_link_q;
  logic [7:0] st_sel;
  logic so_q;

  assign rx_byte = {shift_q, spi_mosi};
  assign cnt_d = first_q ? 3'h1 : cnt_q + 3'h1;
  assign byte_done = (cnt_d == 3'h0);

  // Frame-scoped flags clear as soon as select rises, no clock needed
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      first_q <= 1'b1;
      op_seen_q <= 1'b0;
      rd_on_q <= 1'b0;
      rd_hi_q <= 1'b0;
    end
    else
    begin
      first_q <= 1'b0;
      if (byte_done && !op_seen_q)
      begin
        op_seen_q <= 1'b1;
        rd_on_q <= (rx_byte == `SFSC_OP_STAT_READ_LO) ||
                   (rx_byte == `SFSC_OP_STAT_READ_HI);
        rd_hi_q <= (rx_byte == `SFSC_OP_STAT_READ_HI);
      end
    end
  end

  // Counter survives select rising so the clk side can judge alignment
  always_ff @(posedge spi_sclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 3'h0;
      shift_q <= 7'h00;
      byte_q <= 8'h00;
      tgl_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      shift_q <= rx_byte[6:0];
      if (byte_done)
      begin
        byte_q <= rx_byte;
        tgl_q <= ~tgl_q;
      end
    end
  end

  always_ff @(posedge spi_sclk or posedge rst)
  begin
    if (rst)
    begin
      st_meta_q <= 16'h0000;
      st_link_q <= 16'h0000;
    end
    else
    begin
      st_meta_q <= status_control_word;
      st_link_q <= st_meta_q;
    end
  end

  assign st_sel = rd_hi_q ? st_link_q[15:8] : st_link_q[7:0];

  // Falling-edge launch; the byte repeats because the index wraps
  always_ff @(negedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      so_q <= 1'b0;
    else
      so_q <= st_sel[3'h7 - cnt_q];
  end

  assign spi_miso = so_q;
  assign spi_miso_oe = ~spi_cs_n & rd_on_q;

  // ----------------------------------------
  // Crossings into clk
  // ----------------------------------------
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_prev_q;
  logic aln_meta_q;
  logic aln_sync_q;
  logic wp_meta_q;
  logic wp_sync_q;

  // Alignment is read only after select rises, when the link clock is still
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
      aln_meta_q <= 1'b0;
      aln_sync_q <= 1'b0;
      wp_meta_q <= 1'b0;
      wp_sync_q <= 1'b0;
    end
    else
    begin
      cs_meta_q <= spi_cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      tgl_meta_q <= tgl_q;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
      aln_meta_q <= (cnt_q == 3'h0);
      aln_sync_q <= aln_meta_q;
      wp_meta_q <= wp_n;
      wp_sync_q <= wp_meta_q;
    end
  end

  logic frame_start;
  logic frame_end;
  logic byte_evt;

  assign frame_start = ~cs_sync_q & cs_prev_q;
  assign frame_end = cs_sync_q & ~cs_prev_q;
  assign byte_evt = tgl_sync_q ^ tgl_prev_q;

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  logic [2:0] nbytes_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] d0_q;
  logic [7:0] d1_q;

  always_ff @(posedge clk)
  begin
    if (rst || frame_start)
      nbytes_q <= 3'h0;
    else if (byte_evt && nbytes_q != 3'h7)
      nbytes_q <= nbytes_q + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      d0_q <= 8'h00;
      d1_q <= 8'h00;
    end
    else if (byte_evt)
    begin
      if (nbytes_q == 3'h0)
        opc_q <= byte_q;
      if (nbytes_q >= 3'h1 && nbytes_q <= 3'h3)
        addr_q <= {addr_q[15:0], byte_q};
      if (nbytes_q == 3'h1)
        d0_q <= byte_q;
      if (nbytes_q == 3'h2)
        d1_q <= byte_q;
    end
  end

  // ----------------------------------------
  // Protection decode
  // ----------------------------------------
  // Size of the guarded region in 4 KB pages, before the invert bit
  function automatic logic [8:0] sfsc_units(input logic [4:0] bp);
    logic [8:0] u;
    u = 9'h000;
    if (bp[2:1] == 2'b11)
      u = `SFSC_ALL_PAGES;
    else if (!bp[4])
    begin
      case (bp[2:0])
        3'h1: u = 9'h010;
        3'h2: u = 9'h020;
        3'h3: u = 9'h040;
        3'h4: u = 9'h080;
        3'h5: u = `SFSC_ALL_PAGES;
        default: u = 9'h000;
      endcase
    end
    else
    begin
      case (bp[2:0])
        3'h1: u = 9'h001;
        3'h2: u = 9'h002;
        3'h3: u = 9'h004;
        3'h4: u = 9'h008;
        3'h5: u = 9'h008;
        default: u = 9'h000;
      endcase
    end
    return u;
  endfunction

  // Only the start address is checked; a block is judged by its first page
  function automatic logic sfsc_guarded(input logic [7:0] page, input logic [4:0] bp,
                                        input logic inv);
    logic [8:0] n;
    logic hit;
    n = sfsc_units(bp);
    hit = bp[3] ? ({1'b0, page} < n) : ({1'b0, page} >= (`SFSC_ALL_PAGES - n));
    return inv ? ~hit : hit;
  endfunction

  // ----------------------------------------
  // Status word state
  // ----------------------------------------
  sfsc_state_e state_q;
  sfsc_kind_e kind_q;
  logic write_latch_flag_q;
  logic [4:0] bp_q;
  logic guard_lo_q;
  logic guard_hi_q;
  logic quad_q;
  logic [2:0] lock_q;
  logic invert_protect_q;
  logic erase_pause_q;
  logic prog_pause_q;
  logic vol_en_q;
  logic rst_en_q;
  logic [15:0] timer_q;
  logic done;

  logic wp_high;
  logic sr_ok;
  logic aligned;
  logic idle;
  logic is_prog;
  logic is_erase;
  logic is_chip;
  logic arr_guard;
  logic chip_ok;
  logic do_sw;
  logic do_prog;
  logic do_erase;
  logic do_chip;
  logic do_suspend;
  logic do_resume;
  logic do_soft_rst;
  logic [15:0] sw_word;

  // With the quad bit set the protect pin is a data line and never guards
  assign wp_high = quad_q | wp_sync_q;
  assign pin_protect_hold_fn = ~quad_q;
  assign quad_lines_on = quad_q;

  always_comb
  begin
    case ({guard_hi_q, guard_lo_q})
      2'b00: sr_ok = 1'b1;
      2'b01: sr_ok = wp_high;
      2'b10: sr_ok = 1'b0;
      2'b11: sr_ok = 1'b0;
      default: sr_ok = 1'b0;
    endcase
  end

  assign aligned = aln_sync_q && nbytes_q != 3'h0;
  assign idle = (state_q == SFSC_ST_IDLE);
  assign is_prog = opc_q == `SFSC_OP_PAGE_PROG || opc_q == `SFSC_OP_QUAD_PROG;
  assign is_erase = opc_q == `SFSC_OP_SECT_ERASE || opc_q == `SFSC_OP_BLK32_ERASE ||
                    opc_q == `SFSC_OP_BLK64_ERASE;
  assign is_chip = opc_q == `SFSC_OP_CHIP_ERASE_A || opc_q == `SFSC_OP_CHIP_ERASE_B;
  assign arr_guard = sfsc_guarded(addr_q[19:12], bp_q, invert_protect_q);
  assign chip_ok = invert_protect_q ? (sfsc_units(bp_q) == `SFSC_ALL_PAGES) :
                   (sfsc_units(bp_q) == 9'h000);

  // Latch must be set for every array change; a status write also accepts the volatile enable
  assign do_sw = frame_end && idle && aligned && opc_q == `SFSC_OP_STATUS_WRITE &&
                 nbytes_q >= 3'h2 && (write_latch_flag_q || vol_en_q) && sr_ok;
  assign do_prog = frame_end && idle && aligned && is_prog && write_latch_flag_q &&
                   !arr_guard && nbytes_q >= `SFSC_PROG_MIN_BYTES;
  assign do_erase = frame_end && idle && aligned && is_erase && write_latch_flag_q &&
                    !arr_guard && nbytes_q == `SFSC_ERASE_BYTES;
  assign do_chip = frame_end && idle && aligned && is_chip && write_latch_flag_q &&
                   chip_ok && nbytes_q == 3'h1;
  assign do_suspend = frame_end && state_q == SFSC_ST_BUSY && opc_q == `SFSC_OP_SUSPEND &&
                      kind_q != SFSC_OP_STAT;
  assign do_resume = frame_end && state_q == SFSC_ST_SUSP && opc_q == `SFSC_OP_RESUME;
  assign do_soft_rst = frame_end && rst_en_q && opc_q == `SFSC_OP_RESET_GO;

  // A single data byte leaves the upper half unchanged
  assign sw_word = {(nbytes_q >= 3'h3) ? d1_q : status_control_word[15:8], d0_q};

  // ----------------------------------------
  // Operation engine
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= SFSC_ST_IDLE;
      kind_q <= SFSC_OP_NONE;
      timer_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        SFSC_ST_IDLE:
        begin
          if ((do_sw && !vol_en_q) || do_prog || do_erase || do_chip)
          begin
            state_q <= SFSC_ST_BUSY;
            kind_q <= do_sw ? SFSC_OP_STAT : (do_prog ? SFSC_OP_PROG : SFSC_OP_ERASE);
            timer_q <= do_sw ? 16'(STAT_WRITE_CYC) : do_prog ? 16'(PROG_CYC) :
                       do_erase ? 16'(ERASE_CYC) : 16'(CHIP_ERASE_CYC);
          end
        end
        SFSC_ST_BUSY:
        begin
          if (do_suspend)
            state_q <= SFSC_ST_SUSP;
          else if (done)
          begin
            state_q <= SFSC_ST_IDLE;
            kind_q <= SFSC_OP_NONE;
          end
          else
            timer_q <= timer_q - 16'h0001;
        end
        SFSC_ST_SUSP:
        begin
          if (do_resume)
            state_q <= SFSC_ST_BUSY;
        end
        default:
          state_q <= SFSC_ST_IDLE;
      endcase
    end
  end

  assign done = (state_q == SFSC_ST_BUSY) && timer_q <= 16'h0001 && !do_suspend;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_start <= 1'b0;
      op_kind <= 2'b00;
      op_addr <= 24'h000000;
    end
    else
    begin
      op_start <= do_prog || do_erase || do_chip;
      if (do_prog || do_erase || do_chip)
      begin
        op_kind <= do_prog ? SFSC_OP_PROG : SFSC_OP_ERASE;
        op_addr <= do_chip ? 24'h000000 : addr_q;
      end
    end
  end

  // ----------------------------------------
  // Write latch and one-shot enables
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      write_latch_flag_q <= 1'b0;
    else if (done || do_soft_rst)
      write_latch_flag_q <= 1'b0;
    else if (frame_end && idle && aligned && nbytes_q == 3'h1)
    begin
      if (opc_q == `SFSC_OP_WRITE_ALLOW)
        write_latch_flag_q <= 1'b1;
      else if (opc_q == `SFSC_OP_WRITE_DISALLOW)
        write_latch_flag_q <= 1'b0;
    end
  end

  // Any frame of at least one byte other than the volatile enable itself, status write included, cancels it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vol_en_q <= 1'b0;
      rst_en_q <= 1'b0;
    end
    else if (frame_end && nbytes_q != 3'h0)
    begin
      vol_en_q <= idle && aligned && opc_q == `SFSC_OP_VOLATILE_EN;
      rst_en_q <= aligned && opc_q == `SFSC_OP_RESET_ENABLE;
    end
  end

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  // Power-up reloads the stored image; the one-zero guard returns to zero-zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bp_q <= nv_init[`SFSC_BIT_BP_HI:`SFSC_BIT_BP_LO];
      guard_lo_q <= nv_init[`SFSC_BIT_GUARD_LO];
      guard_hi_q <= nv_init[`SFSC_BIT_GUARD_HI] & nv_init[`SFSC_BIT_GUARD_LO];
      quad_q <= nv_init[`SFSC_BIT_QUAD];
      lock_q <= nv_init[`SFSC_BIT_LOCK_HI:`SFSC_BIT_LOCK_LO];
      invert_protect_q <= nv_init[`SFSC_BIT_INVERT];
    end
    else if (do_sw)
    begin
      bp_q <= sw_word[`SFSC_BIT_BP_HI:`SFSC_BIT_BP_LO];
      guard_lo_q <= sw_word[`SFSC_BIT_GUARD_LO];
      guard_hi_q <= sw_word[`SFSC_BIT_GUARD_HI];
      quad_q <= sw_word[`SFSC_BIT_QUAD];
      lock_q <= lock_q | sw_word[`SFSC_BIT_LOCK_HI:`SFSC_BIT_LOCK_LO];
      invert_protect_q <= sw_word[`SFSC_BIT_INVERT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      erase_pause_q <= 1'b0;
      prog_pause_q <= 1'b0;
    end
    else if (do_suspend)
    begin
      erase_pause_q <= (kind_q == SFSC_OP_ERASE);
      prog_pause_q <= (kind_q == SFSC_OP_PROG);
    end
    else if (do_resume)
    begin
      erase_pause_q <= 1'b0;
      prog_pause_q <= 1'b0;
    end
  end

  assign status_control_word = {erase_pause_q, invert_protect_q, lock_q, prog_pause_q,
                                quad_q, guard_hi_q, guard_lo_q, bp_q, write_latch_flag_q,
                                state_q == SFSC_ST_BUSY};

endmodule

`default_nettype wire

// ==== core/sfsc_defines.svh ====
// Purpose: Constants for the serial flash status word and command framing.
// Assumes: One status word of 16 bits; opcodes are one byte, sent MSB first.
// Notes: Busy-time counts are defaults for the top-level parameters.
`ifndef SFSC_DEFINES_SVH
`define SFSC_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFSC_OP_WRITE_ALLOW 8'h06
`define SFSC_OP_WRITE_DISALLOW 8'h04
`define SFSC_OP_VOLATILE_EN 8'h50
`define SFSC_OP_STAT_READ_LO 8'h05
`define SFSC_OP_STAT_READ_HI 8'h35
`define SFSC_OP_STATUS_WRITE 8'h01
`define SFSC_OP_PAGE_PROG 8'h02
`define SFSC_OP_QUAD_PROG 8'h32
`define SFSC_OP_SECT_ERASE 8'h20
`define SFSC_OP_BLK32_ERASE 8'h52
`define SFSC_OP_BLK64_ERASE 8'hD8
`define SFSC_OP_CHIP_ERASE_A 8'hC7
`define SFSC_OP_CHIP_ERASE_B 8'h60
`define SFSC_OP_RESET_ENABLE 8'h66
`define SFSC_OP_RESET_GO 8'h99
`define SFSC_OP_SUSPEND 8'h75
`define SFSC_OP_RESUME 8'h7A

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define SFSC_BIT_BUSY 0
`define SFSC_BIT_WRITE_LATCH 1
`define SFSC_BIT_BP_LO 2
`define SFSC_BIT_BP_HI 6
`define SFSC_BIT_GUARD_LO 7
`define SFSC_BIT_GUARD_HI 8
`define SFSC_BIT_QUAD 9
`define SFSC_BIT_PROG_PAUSE 10
`define SFSC_BIT_LOCK_LO 11
`define SFSC_BIT_LOCK_HI 13
`define SFSC_BIT_INVERT 14
`define SFSC_BIT_ERASE_PAUSE 15

// ----------------------------------------
// Busy durations in clk cycles, frame lengths in bytes, and the array size in pages
// ----------------------------------------
`define SFSC_STAT_WRITE_CYC 64
`define SFSC_PROG_CYC 128
`define SFSC_ERASE_CYC 256
`define SFSC_CHIP_ERASE_CYC 1024
`define SFSC_PROG_MIN_BYTES 3'd5
`define SFSC_ERASE_BYTES 3'd4
`define SFSC_ALL_PAGES 9'h100

`endif

// ==== core/sfsc_pkg.sv ====
// Purpose: Types for the serial flash status and command frame block.
// Assumes: Shared by the design module, its checker and the bench.
// Notes: Engine states are Gray coded along idle, busy, suspended.
package sfsc_pkg;

  typedef enum logic [1:0] {
    SFSC_ST_IDLE = 2'b00,
    SFSC_ST_BUSY = 2'b01,
    SFSC_ST_SUSP = 2'b11
  } sfsc_state_e;

  typedef enum logic [1:0] {
    SFSC_OP_NONE = 2'b00,
    SFSC_OP_STAT = 2'b01,
    SFSC_OP_PROG = 2'b10,
    SFSC_OP_ERASE = 2'b11
  } sfsc_kind_e;

endpackage

// ==== test/sfsc_top_asserts.sv ====
// Purpose: Port-level checks for the status word and command framing block.
// Assumes: One clk domain; rst synchronous, active high.
// Notes: Bound into sfsc_top below the module.
`timescale 1ns/1ps
`default_nettype none
module sfsc_top_chk
  import sfsc_pkg::*;
#(
  parameter int CHIP_ERASE_CYC = 1024
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic wp_n,
  input wire logic [15:0] status_control_word,
  input wire logic quad_lines_on,
  input wire logic pin_protect_hold_fn,
  input wire logic op_start,
  input wire logic [1:0] op_kind
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] busy_cnt_q;
  // Resume restarts the remaining count, so one bound covers every run
  always_ff @(posedge clk)
  begin
    if (rst || !status_control_word[0])
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= busy_cnt_q + 16'h0001;
  end
  sequence busy_run_s;
    status_control_word[0] [*4];
  endsequence
  sequence pin_low_s;
    (status_control_word[8:7] == 2'b01 && !status_control_word[9] && !wp_n) [*4];
  endsequence
  start_busy_a: assert property (op_start |-> busy_run_s)
    else $error("operation started without busy");
  start_latch_a: assert property (op_start |-> status_control_word[1])
    else $error("operation started with latch clear");
  start_pulse_a: assert property (op_start |=> !op_start && op_kind[1])
    else $error("start pulse too long or bad kind");
  busy_limit_a: assert property (int'(busy_cnt_q) <= CHIP_ERASE_CYC + 8)
    else $error("busy never ends");
  lock_keep_a: assert property (1'b1 |=>
    ($past(status_control_word[13:11]) & ~status_control_word[13:11]) == 3'b000)
    else $error("lock bit cleared");
  otp_guard_a: assert property (&status_control_word[8:7] |=>
    $stable({status_control_word[14:11], status_control_word[9:2]}))
    else $error("status changed under permanent guard");
  pin_lock_a: assert property (pin_low_s |=> $stable(status_control_word[9:2]))
    else $error("status changed with protect pin low");
  quad_pins_a: assert property (quad_lines_on == status_control_word[9] &&
    pin_protect_hold_fn == !status_control_word[9])
    else $error("quad pin function mismatch");
  oe_idle_a: assert property (spi_cs_n |-> !spi_miso_oe)
    else $error("output driven while deselected");
endmodule
bind sfsc_top sfsc_top_chk #(.CHIP_ERASE_CYC(CHIP_ERASE_CYC)) u_sfsc_top_chk (
  .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe), .wp_n(wp_n),
  .status_control_word(status_control_word), .quad_lines_on(quad_lines_on),
  .pin_protect_hold_fn(pin_protect_hold_fn), .op_start(op_start), .op_kind(op_kind));
`default_nettype wire

// ==== test/sfsc_host_model.sv ====
// Purpose: Host serial controller that frames commands, mode 0.
// Assumes: Serial clock half period 80 ns, idle low between frames.
// Notes: Released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module sfsc_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // ----------------
  // Frame engine
  // ----------------
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  task automatic xfer(input logic [63:0] d, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    // Offset keeps serial edges off the system clock edges
    #1.7;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_mosi = d[63 - i];
      #80 spi_sclk = 1'b1;
      if (i >= 8)
        rd = {rd[14:0], spi_miso};
      #80 spi_sclk = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_serial_flash_status_and_command_frame.sv ====
// Purpose: Self-checking bench for the status word and command framing block.
// Assumes: Host model makes the serial clock; status write busy count shortened, others set to LONG.
// Notes: Expected status is tracked in ex; only the second power cycle reloads it from the design's word.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_status_and_command_frame;
  import sfsc_pkg::*;
  localparam int LONG = 600;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic [15:0] nv_init = 16'h0000;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic quad_lines_on, pin_protect_hold_fn, op_start;
  logic [15:0] status_control_word, ex, rd;
  logic [1:0] op_kind;
  logic [23:0] op_addr;
  int error_cnt = 0;
  int checks_done = 0;
  int starts = 0;
  int oe_n = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) if (op_start === 1'b1) starts++;
  always @(negedge clk) if (spi_miso_oe === 1'b1) oe_n++;
  sfsc_top #(.STAT_WRITE_CYC(8), .PROG_CYC(LONG), .ERASE_CYC(LONG), .CHIP_ERASE_CYC(LONG))
  u_sfsc_top (.clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .wp_n(wp_n),
    .nv_init(nv_init), .status_control_word(status_control_word),
    .quad_lines_on(quad_lines_on), .pin_protect_hold_fn(pin_protect_hold_fn),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr));
  sfsc_host_model u_sfsc_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [15:0] after_wr(input logic [15:0] o, input logic [15:0] n);
    return (o & 16'h8403) | (n & 16'h43FC) | ((o | n) & 16'h3800);
  endfunction
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cs();
    chk({16'h0000, status_control_word}, {16'h0000, ex});
  endtask
  task automatic fr(input logic [7:0] c, input logic [55:0] r, input int n);
    u_sfsc_host_model.xfer({c, r}, n, rd);
  endtask
  task automatic idle();
    int k;
    k = 0;
    while (status_control_word[0] !== 1'b0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 3000)
    begin
      error_cnt++;
      $display("Error %0t: busy stuck", $time);
      results();
    end
  endtask
  task automatic por(input logic [15:0] n);
    @(negedge clk);
    rst = 1'b1;
    nv_init = n;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    ex = n & 16'h7BFC;
    if (ex[8:7] == 2'b10)
      ex[8:7] = 2'b00;
    cs();
    chk({30'h0, quad_lines_on, pin_protect_hold_fn}, {30'h0, ex[9], ~ex[9]});
  endtask
  task automatic rdchk();
    oe_n = 0;
    fr(8'h05, '0, 24);
    chk({16'h0000, rd}, {16'h0000, ex[7:0], ex[7:0]});
    chk(32'(oe_n > 0), 32'h1);
    fr(8'h35, '0, 24);
    chk({16'h0000, rd}, {16'h0000, ex[15:8], ex[15:8]});
  endtask
  task automatic wr(input logic [15:0] v, input bit ok);
    fr(8'h06, '0, 8);
    oe_n = 0;
    fr(8'h01, {v[7:0], v[15:8], 40'h0}, 24);
    chk(32'(oe_n), 32'h0);
    idle();
    if (ok)
      ex = after_wr(ex, v);
    else
      fr(8'h04, '0, 8);
    cs();
  endtask
  task automatic op(input logic [7:0] c, input logic [23:0] a, input int n, input bit go,
    input bit sus);
    int s0;
    logic [15:0] p;
    s0 = starts;
    p = (c == 8'h02 || c == 8'h32) ? 16'h0400 : 16'h8000;
    fr(8'h06, '0, 8);
    fr(c, {a, 32'($urandom())}, n);
    chk(32'(starts - s0), {31'h0, go});
    ex[1] = 1'b1;
    if (go)
    begin
      chk({6'h0, op_kind, op_addr}, {6'h0, (p[10] ? 2'd2 : 2'd3), (n == 8 ? 24'h0 : a)});
      ex[0] = 1'b1;
      cs();
      if (sus)
      begin
        fr(8'h75, '0, 8);
        ex = (ex & 16'hFFFE) | p;
        cs();
        fr(8'h7A, '0, 8);
        ex = (ex & ~p) | 16'h0001;
        cs();
      end
      idle();
      ex[1:0] = 2'b00;
      cs();
    end
    else
    begin
      cs();
      fr(8'h04, '0, 8);
      ex[1] = 1'b0;
    end
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    logic [15:0] v;
    logic [23:0] a;
    void'($urandom(32'h0DF026D4));
    v = 16'($urandom());
    v[8:7] = 2'b10;
    por(v);
    rdchk();
    $display("Test reset finished");
    fr(8'h01, {16'hFFFF, 40'h0}, 24);
    cs();
    fr(8'h06, '0, 9);
    cs();
    fr(8'h06, '0, 8);
    ex[1] = 1'b1;
    cs();
    fr(8'h04, '0, 8);
    ex[1] = 1'b0;
    cs();
    fr(8'h06, '0, 8);
    fr(8'h66, '0, 8);
    fr(8'h99, '0, 8);
    cs();
    $display("Test latch finished");
    repeat (3)
    begin
      v = 16'($urandom()) & 16'hFC7F;
      wr(v, 1'b1);
      rdchk();
    end
    v = 16'($urandom()) & 16'hFC7F;
    fr(8'h50, '0, 8);
    fr(8'h01, {v[7:0], v[15:8], 40'h0}, 24);
    ex = after_wr(ex, v);
    cs();
    $display("Test write finished");
    wr(16'h0080, 1'b1);
    @(negedge clk);
    wp_n = 1'b0;
    wr(16'h00FC, 1'b0);
    @(negedge clk);
    wp_n = 1'b1;
    wr(16'h0000, 1'b1);
    wr(16'h0100, 1'b1);
    wr(16'h0000, 1'b0);
    por(status_control_word);
    $display("Test guard finished");
    wr(16'h0004, 1'b1);
    a = 24'($urandom_range(32'h000EFFFF, 0));
    op(8'h02, a, 40, 1'b1, 1'b1);
    op(8'h32, a, 40, 1'b1, 1'b0);
    op(8'h02, a, 41, 1'b0, 1'b0);
    op(8'h20, 24'h0F1000, 32, 1'b0, 1'b0);
    op(8'h20, a, 32, 1'b1, 1'b1);
    op(8'h52, a, 32, 1'b1, 1'b0);
    op(8'hD8, a, 32, 1'b1, 1'b0);
    op(8'hC7, '0, 8, 1'b0, 1'b0);
    wr(16'h401C, 1'b1);
    op(8'hC7, '0, 8, 1'b1, 1'b0);
    op(8'h60, '0, 8, 1'b1, 1'b0);
    $display("Test array finished");
    wr(16'h0180, 1'b1);
    wr(16'h00FC, 1'b0);
    $display("Test permanent guard finished");
    results();
  end
endmodule
`default_nettype wire
